// *** rtl/gfm_pkg.sv ***
// gfm_pkg: shared types and constants of the general pin function multiplexer.
// assumes a single 200 MHz clock domain and no register bus; software drives a write strobe.
package gfm_pkg;

  // ****************************************************************
  // pin indices
  // ****************************************************************
  localparam int GFM_NPINS = 14;
  localparam int GFM_NPINS_REDUCED = 9;
  localparam logic [3:0] GFM_PIN_ONE = 4'h0;
  localparam logic [3:0] GFM_PIN_TWO = 4'h1;
  localparam logic [3:0] GFM_PIN_THREE = 4'h2;
  localparam logic [3:0] GFM_PIN_FOUR = 4'h3;
  localparam logic [3:0] GFM_PIN_FIVE = 4'h4;
  localparam logic [3:0] GFM_PIN_CHOICE_ZERO = 4'h8;
  localparam logic [3:0] GFM_PIN_CHOICE_ONE = 4'h9;
  localparam logic [3:0] GFM_PIN_DTR = 4'ha;
  localparam logic [3:0] GFM_PIN_DSR = 4'hb;
  localparam logic [3:0] GFM_PIN_DCD = 4'hc;
  localparam logic [3:0] GFM_PIN_RI = 4'hd;

  // ****************************************************************
  // function codes
  // ****************************************************************
  typedef enum logic [3:0] {
    GFM_FN_DISABLED = 4'h0,
    GFM_FN_INPUT = 4'h1,
    GFM_FN_OUTPUT = 4'h2,
    GFM_FN_EXT_IRQ = 4'h3,
    GFM_FN_SPI_CS1 = 4'h4,
    GFM_FN_GNSS_SUPPLY = 4'h5,
    GFM_FN_GNSS_READY = 4'h6,
    GFM_FN_GNSS_RTC = 4'h7,
    GFM_FN_WIFI_EN = 4'h8,
    GFM_FN_RING = 4'h9,
    GFM_FN_SIM_DETECT = 4'ha,
    GFM_FN_SIM_HOTPLUG = 4'hb
  } gfm_func_t;

  localparam gfm_func_t GFM_FN_RESET = GFM_FN_DISABLED;

  // edge select of an interrupt input
  typedef enum logic [1:0] {
    GFM_EDGE_RISE = 2'h0,
    GFM_EDGE_FALL = 2'h1,
    GFM_EDGE_BOTH = 2'h2
  } gfm_edge_t;

  // configuration write from software or the command interface
  typedef struct packed {
    logic [3:0] pin;
    gfm_func_t func;
    logic level;
    gfm_edge_t edge_sel;
  } gfm_cfg_t;

  // pad controls of one pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_down;
  } gfm_pad_t;

  // write-response state machine
  typedef enum logic [2:0] {
    GFM_ST_IDLE = 3'b001,
    GFM_ST_ACK = 3'b010,
    GFM_ST_NAK = 3'b100
  } gfm_state_t;

endpackage

// *** rtl/gfm_pin_slice.sv ***
// gfm_pin_slice: pad control and input sampling of one pin.
// assumes the pin input is synchronous to clk.
`timescale 1ns/1ps
module gfm_pin_slice (
  input wire logic clk,
  input wire logic arst_n,
  input wire gfm_pkg::gfm_func_t func,
  input wire logic level,
  input wire logic alt_level,
  input wire gfm_pkg::gfm_edge_t edge_sel,
  input wire logic irq_clear,
  input wire logic pin_in,
  output gfm_pkg::gfm_pad_t pad,
  output logic sample,
  output logic irq_pending
);
  import gfm_pkg::*;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic sample_r;
  logic irq_r;
  gfm_pad_t pad_r;
  wire drives = (func == GFM_FN_OUTPUT) || (func == GFM_FN_SPI_CS1) || (func == GFM_FN_GNSS_SUPPLY) ||
                (func == GFM_FN_GNSS_RTC) || (func == GFM_FN_WIFI_EN) || (func == GFM_FN_RING);
  wire drive_val = (func == GFM_FN_OUTPUT) ? level : alt_level;
  wire rise = pin_in && !sample_r;
  wire fall = !pin_in && sample_r;
  wire edge_hit = (edge_sel == GFM_EDGE_RISE) ? rise : (edge_sel == GFM_EDGE_FALL) ? fall : (rise || fall);
  wire irq_set = (func == GFM_FN_EXT_IRQ) && edge_hit;
  gfm_pad_t pad_nxt;
  assign pad_nxt.out = drives ? drive_val : 1'b0;
  assign pad_nxt.oe = drives;
  assign pad_nxt.pull_down = (func == GFM_FN_DISABLED);

  // ****************************************************************
  // registers
  // ****************************************************************
  // sample every cycle so the edge detector has history whatever the function
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_r <= 1'b0;
      irq_r <= 1'b0;
      pad_r <= '{out: 1'b0, oe: 1'b0, pull_down: 1'b1};
    end else begin
      sample_r <= pin_in;
      irq_r <= irq_set | (irq_r & ~irq_clear); // set beats clear
      pad_r <= pad_nxt;
    end
  end

  assign pad = pad_r;
  assign sample = sample_r;
  assign irq_pending = irq_r;
endmodule

// *** rtl/gfm_top.sv ***
// gfm_top: per-pin function multiplexer for the fourteen general pins.
// assumes a configuration source that raises cfg_valid for one cycle per write.
// Function
// - full variant: fourteen pins configured by on-module software
// - reduced variant: nine pins, configured through the command interface
// - disabled pin: driver off, pull-down on
// - input pin: sampled level reported
// - output pin: drives programmed level
// - interrupt detect only on pin three, choice pins, DTR, DSR, DCD, RI
// - pin four may carry second SPI chip select
// - pin two may switch satellite receiver supply
// - pin three may sense satellite data ready
// - pin four may carry RTC sync to the receiver
// - pin one may switch the wireless module on or off
// - reduced variant: RI may act as UART ring indicator
// - reduced variant: pin five may sense SIM presence
// - hot-plug mode enables SIM on insertion, disables on removal
`timescale 1ns/1ps
module gfm_top #(
  parameter bit REDUCED = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_valid,
  input wire gfm_pkg::gfm_cfg_t cfg,
  input wire logic [13:0] irq_clear,
  input wire logic [13:0] pin_in,
  input wire logic spi_cs1_n,
  input wire logic gnss_supply_on,
  input wire logic gnss_rtc_sync,
  input wire logic wifi_on,
  input wire logic ring_active,
  output logic cfg_ack,
  output logic cfg_nak,
  output logic [13:0] pin_out,
  output logic [13:0] pin_oe,
  output logic [13:0] pin_pull_down,
  output logic [13:0] pin_level,
  output logic [13:0] irq_pending,
  output logic gnss_data_ready,
  output logic sim_present,
  output logic sim_enable
);
  import gfm_pkg::*;

  // ****************************************************************
  // legality of a requested function
  // ****************************************************************
  wire [3:0] p = cfg.pin;
  wire in_range = REDUCED ? ((p < 4'h8) || (p == GFM_PIN_RI)) : (p < 4'he);
  wire irq_ok = !REDUCED && ((p == GFM_PIN_THREE) || (p >= GFM_PIN_CHOICE_ZERO));
  logic legal;
  // reduced variant drops the application-software functions, adds the SIM and ring ones
  always_comb begin
    case (cfg.func)
      GFM_FN_DISABLED, GFM_FN_INPUT, GFM_FN_OUTPUT: legal = 1'b1;
      GFM_FN_EXT_IRQ: legal = irq_ok;
      GFM_FN_SPI_CS1: legal = !REDUCED && (p == GFM_PIN_FOUR);
      GFM_FN_GNSS_SUPPLY: legal = !REDUCED && (p == GFM_PIN_TWO);
      GFM_FN_GNSS_READY: legal = !REDUCED && (p == GFM_PIN_THREE);
      GFM_FN_GNSS_RTC: legal = !REDUCED && (p == GFM_PIN_FOUR);
      GFM_FN_WIFI_EN: legal = !REDUCED && (p == GFM_PIN_ONE);
      GFM_FN_RING: legal = REDUCED && (p == GFM_PIN_RI);
      GFM_FN_SIM_DETECT, GFM_FN_SIM_HOTPLUG: legal = REDUCED && (p == GFM_PIN_FIVE);
      default: legal = 1'b0;
    endcase
  end
  wire accept = cfg_valid && in_range && legal;

  // ****************************************************************
  // configuration storage, one slot per pin
  // ****************************************************************
  gfm_func_t func_r [GFM_NPINS];
  logic [13:0] level_r;
  gfm_edge_t edge_r [GFM_NPINS];
  gfm_state_t state_r;
  gfm_state_t state_nxt;
  gfm_pad_t pad [GFM_NPINS];
  logic [13:0] sample;
  logic [13:0] irq_q;
  logic [13:0] alt_level;

  // alternate drive sources routed by pin position
  always_comb begin
    alt_level = '0;
    alt_level[GFM_PIN_ONE] = wifi_on;
    alt_level[GFM_PIN_TWO] = gnss_supply_on;
    alt_level[GFM_PIN_FOUR] = (func_r[GFM_PIN_FOUR] == GFM_FN_SPI_CS1) ? spi_cs1_n : gnss_rtc_sync;
    alt_level[GFM_PIN_RI] = ~ring_active; // ring indicator is active low on the line
  end

  genvar gi;
  generate
    for (gi = 0; gi < GFM_NPINS; gi++) begin : g_pin
      // a rejected write leaves the slot untouched, so exactly one function stands
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          func_r[gi] <= GFM_FN_RESET;
          level_r[gi] <= 1'b0;
          edge_r[gi] <= GFM_EDGE_RISE;
        end else if (accept && (p == 4'(gi))) begin
          func_r[gi] <= cfg.func;
          level_r[gi] <= cfg.level;
          edge_r[gi] <= cfg.edge_sel;
        end
      end

      gfm_pin_slice u_slice (
        .clk(clk),
        .arst_n(arst_n),
        .func(func_r[gi]),
        .level(level_r[gi]),
        .alt_level(alt_level[gi]),
        .edge_sel(edge_r[gi]),
        .irq_clear(irq_clear[gi]),
        .pin_in(pin_in[gi]),
        .pad(pad[gi]),
        .sample(sample[gi]),
        .irq_pending(irq_q[gi])
      );
      assign pin_out[gi] = pad[gi].out;
      assign pin_oe[gi] = pad[gi].oe;
      assign pin_pull_down[gi] = pad[gi].pull_down;
    end
  endgenerate

  // ****************************************************************
  // write response
  // ****************************************************************
  always_comb begin
    case (state_r)
      GFM_ST_IDLE, GFM_ST_ACK, GFM_ST_NAK: begin
        if (cfg_valid) begin
          state_nxt = accept ? GFM_ST_ACK : GFM_ST_NAK;
        end else begin
          state_nxt = GFM_ST_IDLE;
        end
      end
      default: state_nxt = GFM_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= GFM_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign cfg_ack = (state_r == GFM_ST_ACK);
  assign cfg_nak = (state_r == GFM_ST_NAK);

  // ****************************************************************
  // sensed functions
  // ****************************************************************
  logic gnss_ready_r;
  logic sim_present_r;
  logic sim_enable_r;
  wire five_det = (func_r[GFM_PIN_FIVE] == GFM_FN_SIM_DETECT) || (func_r[GFM_PIN_FIVE] == GFM_FN_SIM_HOTPLUG);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gnss_ready_r <= 1'b0;
      sim_present_r <= 1'b0;
      sim_enable_r <= 1'b0;
    end else begin
      gnss_ready_r <= (func_r[GFM_PIN_THREE] == GFM_FN_GNSS_READY) && sample[GFM_PIN_THREE];
      sim_present_r <= five_det && sample[GFM_PIN_FIVE];
      // outside hot-plug mode the SIM stays enabled; a card is assumed present
      sim_enable_r <= (func_r[GFM_PIN_FIVE] == GFM_FN_SIM_HOTPLUG) ? sample[GFM_PIN_FIVE] : 1'b1;
    end
  end

  assign pin_level = sample;
  assign irq_pending = irq_q;
  assign gnss_data_ready = gnss_ready_r;
  assign sim_present = sim_present_r;
  assign sim_enable = sim_enable_r;
endmodule

// *** bench/gfm_props.sv ***
// gfm_props: port timing checks of the pin function multiplexer, either variant.
// assumes it is bound onto gfm_top and sees only its ports.
`timescale 1ns/1ps
module gfm_props #(
  parameter bit REDUCED = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_valid,
  input wire gfm_pkg::gfm_cfg_t cfg,
  input wire logic [13:0] irq_clear,
  input wire logic [13:0] pin_in,
  input wire logic cfg_ack,
  input wire logic cfg_nak,
  input wire logic [13:0] pin_oe,
  input wire logic [13:0] pin_pull_down,
  input wire logic [13:0] pin_level,
  input wire logic [13:0] irq_pending
);
  import gfm_pkg::*;
  logic [1:0] up_r;
  // past values from inside reset mean nothing, so wait a few edges first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  // legality of the pin-specific functions
  wire up = up_r == 2'h3;
  wire is_alt = cfg.func inside {GFM_FN_SPI_CS1, GFM_FN_GNSS_SUPPLY, GFM_FN_GNSS_READY, GFM_FN_GNSS_RTC, GFM_FN_WIFI_EN};
  wire alt_ok = !REDUCED && ((cfg.pin == GFM_PIN_FOUR && cfg.func inside {GFM_FN_SPI_CS1, GFM_FN_GNSS_RTC})
    || (cfg.pin == GFM_PIN_TWO && cfg.func == GFM_FN_GNSS_SUPPLY) || (cfg.pin == GFM_PIN_ONE && cfg.func == GFM_FN_WIFI_EN)
    || (cfg.pin == GFM_PIN_THREE && cfg.func == GFM_FN_GNSS_READY));
  wire irq_ok = !REDUCED && (cfg.pin == GFM_PIN_THREE || (cfg.pin >= GFM_PIN_CHOICE_ZERO && cfg.pin <= GFM_PIN_RI));
  // the reduced build has no host choice or modem control pins besides RI
  wire pin_ok = cfg.pin <= GFM_PIN_RI && (!REDUCED || cfg.pin < 4'h8 || cfg.pin == GFM_PIN_RI);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  one_answer_a: assert property (cfg_valid |=> cfg_ack != cfg_nak)
    else $error("write not answered exactly once");
  answer_cause_a: assert property (up && (cfg_ack || cfg_nak) |-> $past(cfg_valid))
    else $error("answer without a write");
  pin_range_a: assert property (cfg_valid && cfg.pin > GFM_PIN_RI |=> cfg_nak)
    else $error("write past last pin accepted");
  basic_ok_a: assert property (cfg_valid && cfg.func <= GFM_FN_OUTPUT && pin_ok |=> cfg_ack)
    else $error("plain function refused");
  irq_pins_a: assert property (cfg_valid && cfg.func == GFM_FN_EXT_IRQ |=> cfg_ack == $past(irq_ok))
    else $error("interrupt pin legality wrong");
  alt_pins_a: assert property (cfg_valid && is_alt |=> cfg_ack == $past(alt_ok))
    else $error("alternate function legality wrong");
  no_drive_pull_a: assert property ((pin_oe & pin_pull_down) == 14'h0)
    else $error("pad driven with pull-down on");
  sample_lag_a: assert property (up |-> pin_level == $past(pin_in))
    else $error("pin level not one cycle behind pad");
  pad_hold_a: assert property (up && $changed({pin_oe, pin_pull_down}) |-> $past(cfg_ack))
    else $error("pad changed without accepted write");
  flag_sticky_a: assert property (up |-> ($past(irq_pending) & ~$past(irq_clear) & ~irq_pending) == 14'h0)
    else $error("pending flag dropped without clear");
  acc_c: cover property (cfg_ack);
  rej_c: cover property (cfg_nak);
  irq_c: cover property ($rose(|irq_pending));
  drive_c: cover property ($rose(|pin_oe));
endmodule
bind gfm_top gfm_props #(.REDUCED(REDUCED)) u_props (.clk, .arst_n, .cfg_valid, .cfg, .irq_clear, .pin_in, .cfg_ack, .cfg_nak,
  .pin_oe, .pin_pull_down, .pin_level, .irq_pending);

// *** bench/gfm_periph.sv ***
// gfm_periph: external peripherals and board seen at the fourteen pads.
// assumes pad controls of gfm_top and a per-pin drive level from the bench.
`timescale 1ns/1ps
module gfm_periph (
  input wire logic clk,
  input wire logic [13:0] pin_out,
  input wire logic [13:0] pin_oe,
  input wire logic [13:0] pin_pull_down,
  input wire logic [13:0] ext_en,
  input wire logic [13:0] ext_lvl,
  output logic [13:0] pin_in
);
  logic wob_r = 1'b0;
  // a pad nobody drives and nothing pulls wanders, so flip it every cycle
  always_ff @(posedge clk) wob_r <= ~wob_r;
  // module drive wins, then the peripheral, then the pull-down
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl) | (~pin_oe & ~ext_en & ~pin_pull_down & {14{wob_r}});
endmodule

// *** bench/gfm_top_tb.sv ***
// gfm_top_tb: directed and random checks of the pin function multiplexer, full and reduced variants.
// assumes gfm_periph and the bound gfm_props are compiled alongside.
`timescale 1ns/1ps
module gfm_top_tb;
  import gfm_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_valid = 1'b0;
  gfm_cfg_t cfg = '0;
  logic [13:0] irq_clear = 14'h3fff;
  logic [13:0] ext_en = 14'h3fff;
  logic [13:0] ext_lvl = 14'h0;
  logic [4:0] alt_src = 5'h0;
  logic [13:0] pin_in, pin_out, pin_oe, pin_pull_down, pin_level, irq_pending;
  logic cfg_ack, cfg_nak, gnss_data_ready;
  logic [13:0] out_red, oe_red;
  logic ack_red, sim_present, sim_enable, sim_present_red, sim_enable_red;
  int failures = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  gfm_top DUT (.clk, .arst_n, .cfg_valid, .cfg, .irq_clear, .pin_in, .spi_cs1_n(alt_src[0]), .gnss_supply_on(alt_src[1]),
    .gnss_rtc_sync(alt_src[2]), .wifi_on(alt_src[3]), .ring_active(alt_src[4]), .cfg_ack, .cfg_nak, .pin_out, .pin_oe,
    .pin_pull_down, .pin_level, .irq_pending, .gnss_data_ready, .sim_present, .sim_enable);
  // reduced build sees the same writes; its pads read the peripheral levels directly
  gfm_top #(.REDUCED(1'b1)) DUT_red (.clk, .arst_n, .cfg_valid, .cfg, .irq_clear, .pin_in(ext_lvl),
    .spi_cs1_n(alt_src[0]), .gnss_supply_on(alt_src[1]), .gnss_rtc_sync(alt_src[2]), .wifi_on(alt_src[3]),
    .ring_active(alt_src[4]), .cfg_ack(ack_red), .cfg_nak(), .pin_out(out_red), .pin_oe(oe_red), .pin_pull_down(),
    .pin_level(), .irq_pending(), .gnss_data_ready(), .sim_present(sim_present_red), .sim_enable(sim_enable_red));
  gfm_periph u_periph (.clk, .pin_out, .pin_oe, .pin_pull_down, .ext_en, .ext_lvl, .pin_in);
  // full variant: ring and sim codes belong to the reduced build only
  function automatic logic legal(input logic [3:0] p, input logic [3:0] f);
    return p <= 4'hd && (f <= 4'h2 || (f == 4'h3 && (p == 4'h2 || p >= 4'h8)) || (f == 4'h4 && p == 4'h3)
      || (f == 4'h5 && p == 4'h1) || (f == 4'h6 && p == 4'h2) || (f == 4'h7 && p == 4'h3) || (f == 4'h8 && p == 4'h0));
  endfunction
  // reduced variant: pins one..eight and RI, plain functions plus ring on RI and SIM sense on pin five
  function automatic logic legal_red(input logic [3:0] p, input logic [3:0] f);
    return (p <= 4'h7 || p == 4'hd) && (f <= 4'h2 || (f == 4'h9 && p == 4'hd) || ((f == 4'ha || f == 4'hb) && p == 4'h4));
  endfunction
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write, then enough cycles for pads and the two-stage sense paths to settle
  task automatic wr(input logic [3:0] p, input logic [3:0] f, input logic l, input logic [1:0] e);
    logic [13:0] oe0;
    oe0 = pin_oe;
    @(posedge clk) #1;
    cfg = {p, gfm_func_t'(f), l, gfm_edge_t'(e)};
    cfg_valid = 1'b1;
    @(posedge clk) #1;
    cfg_valid = 1'b0;
    chk(14'(cfg_ack), 14'(legal(p, f)));
    chk(14'(ack_red), 14'(legal_red(p, f)));
    repeat (3) @(posedge clk) #1;
    if (!legal(p, f)) chk(pin_oe, oe0);
  endtask
  task automatic pad(input logic [3:0] p, input logic [3:0] f, input logic l);
    case (f)
      4'h0: chk(14'({pin_oe[p], pin_pull_down[p]}), 14'h1);
      4'h1: chk(14'({pin_oe[p], pin_level[p]}), 14'(ext_lvl[p]));
      4'h2: chk(14'({pin_oe[p], pin_out[p], pin_pull_down[p]}), 14'({1'b1, l, 1'b0}));
      4'h4: chk(14'({pin_oe[p], pin_out[p]}), 14'({1'b1, alt_src[0]}));
      4'h5: chk(14'({pin_oe[p], pin_out[p]}), 14'({1'b1, alt_src[1]}));
      4'h6: chk(14'(gnss_data_ready), 14'(ext_lvl[2]));
      4'h7: chk(14'({pin_oe[p], pin_out[p]}), 14'({1'b1, alt_src[2]}));
      4'h8: chk(14'({pin_oe[p], pin_out[p]}), 14'({1'b1, alt_src[3]}));
      4'h9: chk(14'({oe_red[13], out_red[13]}), 14'({1'b1, ~alt_src[4]}));
      4'ha: chk(14'({sim_present_red, sim_enable_red}), 14'({ext_lvl[4], 1'b1}));
      4'hb: chk(14'({sim_present_red, sim_enable_red}), 14'({ext_lvl[4], ext_lvl[4]}));
      default: ;
    endcase
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the length of the run
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h5e25));
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    chk(pin_oe, 14'h0);
    chk(pin_pull_down, 14'h3fff);
    chk(irq_pending, 14'h0);
    $display("test reset done");
    // codes zero to eight on every index first, then random writes
    for (int i = 0; i < 344; i++) begin
      logic [3:0] p, f;
      p = i < 144 ? 4'(i / 9) : 4'($urandom);
      f = i < 144 ? 4'(i % 9) : 4'($urandom);
      ext_lvl = 14'($urandom);
      alt_src = 5'($urandom);
      wr(p, f, 1'($urandom), 2'h0);
      if (legal(p, f) || legal_red(p, f)) pad(p, f, cfg.level);
    end
    chk(14'({sim_present, sim_enable}), 14'h1);
    $display("test function select done");
    // each edge choice on DTR: a rise, a clear, then a fall
    for (int e = 0; e < 3; e++) begin
      ext_lvl[10] = 1'b0;
      wr(4'ha, 4'h3, 1'b0, 2'(e));
      irq_clear = 14'h0;
      ext_lvl[10] = 1'b1;
      repeat (3) @(posedge clk) #1;
      chk(14'(irq_pending[10]), 14'(e != 1));
      irq_clear = 14'h3fff;
      @(posedge clk) #1;
      irq_clear = 14'h0;
      @(posedge clk) #1;
      chk(14'(irq_pending[10]), 14'h0);
      ext_lvl[10] = 1'b0;
      repeat (3) @(posedge clk) #1;
      chk(14'(irq_pending[10]), 14'(e != 0));
      irq_clear = 14'h3fff;
    end
    $display("test interrupt done");
    report_and_stop();
  end
endmodule
